// ==== hw/epu_map.vh ====
// Purpose: command codes, option codes and reset values for the update and frame memory block
// Assumes: byte-wide command stream with a command/data flag per byte
// Notes: definitions only
`ifndef EPU_MAP_VH
`define EPU_MAP_VH
// Command codes
`define EPU_CMD_UPD_OPT 8'h22
`define EPU_CMD_WR_MONO 8'h24
`define EPU_CMD_WR_RED 8'h26
`define EPU_CMD_RD_MEM 8'h27
`define EPU_CMD_RD_SEL 8'h41
`define EPU_CMD_ACTIVATE 8'h20
// Update option codes
`define EPU_OPT_POR 8'hff
`define EPU_OPT_DISP1 8'hc7
`define EPU_OPT_DISP2 8'hcf
`define EPU_OPT_TSLUT1 8'hb1
`define EPU_OPT_TSLUT2 8'hb9
`define EPU_OPT_LUT1 8'h91
`define EPU_OPT_LUT2 8'h99
// Read select reset value and selector bit
`define EPU_RDSEL_POR 8'h00
`define EPU_RDSEL_BIT 0
// Frame memory geometry: 400 x 300 pixels, 8 pixels a byte
`define EPU_MEM_WORDS 15000
`define EPU_ADDR_W 14
`define EPU_DUMMY_BYTE 8'h00
// Stage codes for the sequencer output
`define EPU_STG_IDLE 3'h0
`define EPU_STG_CLK 3'h1
`define EPU_STG_ANA_ON 3'h2
`define EPU_STG_DISP 3'h3
`define EPU_STG_ANA_OFF 3'h4
`define EPU_STG_TS 3'h5
`define EPU_STG_LUT 3'h6
`define EPU_STG_OSC_OFF 3'h7
`define EPU_STAGE_CYC 8
`endif

// ==== hw/epu_frame_mem.v ====
// Purpose: one frame memory plane, byte wide, one address shared by the write and the read
// Assumes: synchronous read, one cycle latency
// Notes: 1 stored bit is the plane's marked colour
`timescale 1ns/1ps
`include "epu_map.vh"
module epu_frame_mem (
  input wire clk, // System clock
  input wire wr_en, // Write strobe
  input wire [`EPU_ADDR_W-1:0] addr, // Byte address
  input wire [7:0] wr_data, // Write byte
  output reg [7:0] rd_data // Read byte, next cycle
);
  // Storage array, no reset so it maps to block memory
  reg [7:0] mem [0:`EPU_MEM_WORDS-1];
  // Write and registered read on the same edge; the read returns the byte held before the write
  always @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule // epu_frame_mem

// ==== hw/epu_seq.v ====
// Purpose: display update sequencer stepping through enabled stages
// Assumes: start is a one-cycle pulse
// Notes: each stage lasts a fixed count of cycles
`timescale 1ns/1ps
`include "epu_map.vh"
module epu_seq (
  input wire clk, // System clock
  input wire rst_b, // Async reset, active low
  input wire start, // Activation pulse
  input wire [7:0] opt, // Update option byte
  output reg [2:0] stage_r, // Current stage code
  output reg disp_mode2_r, // Display or LUT uses mode 2
  output wire busy // Sequence running
);
  // Step list for one option, five stages packed, idle ends it
  reg [14:0] plan_r; // Remaining stages, low first
  reg [3:0] cnt_r; // Cycles in stage
  assign busy = (stage_r != `EPU_STG_IDLE);
  // Stage list per option
  function [14:0] plan_of;
    input [7:0] o;
    begin
      case (o)
        `EPU_OPT_DISP1, `EPU_OPT_DISP2:
          plan_of = {`EPU_STG_OSC_OFF, `EPU_STG_ANA_OFF, `EPU_STG_DISP,
                     `EPU_STG_ANA_ON, `EPU_STG_CLK};
        `EPU_OPT_TSLUT1, `EPU_OPT_TSLUT2:
          plan_of = {`EPU_STG_IDLE, `EPU_STG_OSC_OFF, `EPU_STG_LUT,
                     `EPU_STG_TS, `EPU_STG_CLK};
        `EPU_OPT_LUT1, `EPU_OPT_LUT2:
          plan_of = {`EPU_STG_IDLE, `EPU_STG_IDLE, `EPU_STG_OSC_OFF,
                     `EPU_STG_LUT, `EPU_STG_CLK};
        default: // Unlisted options run nothing
          plan_of = 15'h0000;
      endcase
    end
  endfunction
  // Stage list of the option now in force, decoded once
  wire [14:0] plan_w; // Packed stage list
  assign plan_w = plan_of(opt);
  // Walk the plan, each stage held a fixed time
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_r <= `EPU_STG_IDLE;
      plan_r <= 15'h0000;
      cnt_r <= 4'h0;
      disp_mode2_r <= 1'b0;
    end else if (!busy) begin
      if (start) begin
        stage_r <= plan_w[2:0];
        plan_r <= {3'h0, plan_w[14:3]};
        disp_mode2_r <= opt[3]; // Bit 3 picks mode 2
        cnt_r <= 4'h0;
      end
    end else if (cnt_r == 4'd`EPU_STAGE_CYC - 4'd1) begin
      stage_r <= plan_r[2:0];
      plan_r <= {3'h0, plan_r[14:3]};
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'd1;
    end
  end
endmodule // epu_seq

// ==== hw/epu_core.v ====
// Purpose: command interpreter for update options and frame memory access
// Assumes: bytes arrive already deserialised, one strobe per byte
// Notes: read bytes are requested by rd_req and answered two cycles later
`timescale 1ns/1ps
`include "epu_map.vh"
module epu_core (
  input wire clk, // System clock, 200 MHz
  input wire rst_b, // Async reset, active low
  input wire byte_vld, // Received byte strobe
  input wire is_data, // 1 data byte, 0 command byte
  input wire [7:0] byte_in, // Received byte
  input wire rd_req, // Host reads one data byte
  output reg [7:0] rd_data_r, // Read answer byte
  output reg rd_vld_r, // Read answer pulse
  output reg [7:0] upd_opt_r, // Current update option
  output reg [7:0] rd_sel_r, // Read plane select parameter
  output wire [2:0] stage, // Sequencer stage code
  output wire disp_mode2, // Mode 2 selected for the run
  output wire seq_busy, // Update sequence running
  output wire [`EPU_ADDR_W-1:0] addr_ptr // Memory address pointer
);
  // Interpreter states, one hot
  localparam ST_IDLE = 5'b00001; // No command in force
  localparam ST_OPT = 5'b00010; // Awaiting option parameter
  localparam ST_WMONO = 5'b00100; // Mono write burst
  localparam ST_WRED = 5'b01000; // Red write burst
  localparam ST_RD = 5'b10000; // Read burst
  reg [4:0] state_r; // Interpreter state
  reg [4:0] state_nxt; // Next state
  reg sel_pend_r; // Awaiting read select parameter
  reg [`EPU_ADDR_W-1:0] ptr_r; // Shared address pointer
  reg dummy_r; // Next read returns dummy
  reg rd_pend_r; // Read issued last cycle
  reg rd_dummy_r; // That read was the dummy
  reg act_r; // Activation pulse
  wire cmd_vld; // Command byte strobe
  wire dat_vld; // Data byte strobe
  wire [7:0] mono_q; // Mono plane read data
  wire [7:0] red_q; // Red plane read data
  wire mono_we; // Mono plane write
  wire red_we; // Red plane write
  wire rd_go; // Accepted read request, dummy or not
  assign cmd_vld = byte_vld & ~is_data;
  assign dat_vld = byte_vld & is_data;
  assign mono_we = dat_vld & state_r[2];
  assign red_we = dat_vld & state_r[3];
  assign rd_go = rd_req & state_r[4];
  assign addr_ptr = ptr_r;

  // Wrapping pointer increment, used by writes and reads
  function [`EPU_ADDR_W-1:0] ptr_inc;
    input [`EPU_ADDR_W-1:0] p;
    begin
      if (p == `EPU_MEM_WORDS - 1) begin
        ptr_inc = {`EPU_ADDR_W{1'b0}};
      end else begin
        ptr_inc = p + 1'b1;
      end
    end
  endfunction

  // Next state: any command ends the burst in force
  always @* begin
    state_nxt = state_r;
    if (cmd_vld) begin
      case (byte_in)
        `EPU_CMD_UPD_OPT: state_nxt = ST_OPT;
        `EPU_CMD_WR_MONO: state_nxt = ST_WMONO;
        `EPU_CMD_WR_RED: state_nxt = ST_WRED;
        `EPU_CMD_RD_MEM: state_nxt = ST_RD;
        default: state_nxt = ST_IDLE;
      endcase
    end else if (dat_vld) begin
      case (state_r)
        ST_OPT: state_nxt = ST_IDLE; // Only one parameter
        ST_IDLE, ST_WMONO, ST_WRED, ST_RD: state_nxt = state_r;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // State, option and select registers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      upd_opt_r <= `EPU_OPT_POR;
      rd_sel_r <= `EPU_RDSEL_POR;
      sel_pend_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      act_r <= cmd_vld && (byte_in == `EPU_CMD_ACTIVATE);
      if (dat_vld && state_r[1]) begin
        upd_opt_r <= byte_in;
      end
      if (cmd_vld) begin
        sel_pend_r <= (byte_in == `EPU_CMD_RD_SEL);
      end else if (dat_vld && sel_pend_r) begin
        rd_sel_r <= byte_in;
        sel_pend_r <= 1'b0;
      end
    end
  end

  // Pointer advances per stored byte and per real read byte
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_r <= {`EPU_ADDR_W{1'b0}};
      dummy_r <= 1'b0;
    end else begin
      if (mono_we || red_we) begin
        ptr_r <= ptr_inc(ptr_r);
      end else if (rd_go && !dummy_r) begin
        ptr_r <= ptr_inc(ptr_r);
      end
      // Pointer is kept across commands, only dummy flag rearms
      if (cmd_vld && byte_in == `EPU_CMD_RD_MEM) begin
        dummy_r <= 1'b1;
      end else if (rd_go) begin
        dummy_r <= 1'b0;
      end
    end
  end

  // Read answer, two cycles after the request
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_r <= 1'b0;
      rd_dummy_r <= 1'b0;
      rd_vld_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      rd_pend_r <= rd_go;
      rd_dummy_r <= dummy_r;
      rd_vld_r <= rd_pend_r;
      if (rd_pend_r) begin
        if (rd_dummy_r) begin
          rd_data_r <= `EPU_DUMMY_BYTE;
        end else if (rd_sel_r[`EPU_RDSEL_BIT]) begin
          rd_data_r <= red_q;
        end else begin
          rd_data_r <= mono_q;
        end
      end
    end
  end

  // Planes store bytes as sent: mono 1 white, red 1 red
  epu_frame_mem u_mono (
    .clk(clk),
    .wr_en(mono_we),
    .addr(ptr_r),
    .wr_data(byte_in),
    .rd_data(mono_q)
  );
  epu_frame_mem u_red (
    .clk(clk),
    .wr_en(red_we),
    .addr(ptr_r),
    .wr_data(byte_in),
    .rd_data(red_q)
  );

  // Update sequencer started by activation
  epu_seq u_seq (
    .clk(clk),
    .rst_b(rst_b),
    .start(act_r),
    .opt(upd_opt_r),
    .stage_r(stage),
    .disp_mode2_r(disp_mode2),
    .busy(seq_busy)
  );
endmodule // epu_core

// ==== testbench/epu_core_assertions.sv ====
// Purpose: port-level checks for the update option and frame memory block
// Assumes: one clock, asynchronous active-low reset
// Notes: stage order and read timing per the hand-over contract
`timescale 1ns/1ps
`include "epu_map.vh"
module epu_core_chk (
  input wire clk, // System clock
  input wire rst_b, // Reset, active low
  input wire byte_vld, // Byte strobe
  input wire is_data, // Data flag
  input wire [7:0] byte_in, // Received byte
  input wire rd_req, // Read request
  input wire [7:0] rd_data_r, // Read byte
  input wire rd_vld_r, // Read pulse
  input wire [7:0] upd_opt_r, // Update option
  input wire [2:0] stage, // Stage code
  input wire disp_mode2, // Mode 2 flag
  input wire seq_busy, // Sequence running
  input wire [`EPU_ADDR_W-1:0] addr_ptr // Pointer
);
  // All checks share the one clock domain
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_latency: assert property (rd_vld_r |-> $past(rd_req, 2))
    else $error("read answer without request");
  a_opt_write: assert property ((byte_vld && !is_data && byte_in == 8'h22 ##2
    byte_vld && is_data) |=> upd_opt_r == $past(byte_in)) else $error("option not taken");
  a_opt_hold: assert property ($changed(upd_opt_r) |-> $past(byte_vld) && $past(is_data))
    else $error("option changed without data");
  a_cmd_keeps_ptr: assert property (byte_vld && !is_data |=> $stable(addr_ptr))
    else $error("command moved pointer");
  a_busy_start: assert property ($rose(seq_busy) |-> stage == 3'h1)
    else $error("run did not start with clock");
  a_stage_len: assert property (($changed(stage) && stage != 3'h0) |=> $stable(stage)[*7])
    else $error("stage too short");
  a_disp_order: assert property (stage == 3'h3 |-> $past(stage) inside {3'h2, 3'h3})
    else $error("display without analog");
  a_lut_order: assert property (stage == 3'h6 |-> $past(stage) inside {3'h1, 3'h5, 3'h6})
    else $error("table load out of order");
  a_mode_hold: assert property ($past(seq_busy) && seq_busy |-> $stable(disp_mode2))
    else $error("mode changed mid run");
  a_first_dummy: assert property ((byte_vld && !is_data && byte_in == 8'h27 ##2 rd_req)
    |-> ##2 rd_vld_r && rd_data_r == 8'h00) else $error("first read not dummy");
  // Main scenarios reached
  c_disp2: cover property (stage == 3'h3 && disp_mode2);
  c_temp: cover property (stage == 3'h5);
  c_read: cover property (rd_vld_r);
endmodule // epu_core_chk
bind epu_core epu_core_chk chk_u (.clk, .rst_b, .byte_vld, .is_data, .byte_in, .rd_req,
  .rd_data_r, .rd_vld_r, .upd_opt_r, .stage, .disp_mode2, .seq_busy, .addr_ptr);

// ==== testbench/epu_host.sv ====
// Purpose: host model sending command, data and read strobes
// Assumes: one byte per strobe, strobes change just after an edge
// Notes: released byte lines show inverted junk, never the old byte
`timescale 1ns/1ps
module epu_host (
  input wire clk, // System clock
  output logic byte_vld = 1'b0, // Byte strobe
  output logic is_data = 1'b0, // Data flag
  output logic [7:0] byte_in = 8'h00, // Byte lines
  output logic rd_req = 1'b0 // Read pulse
);
  // One byte; flag low for a command, high for data
  task send(input logic d, input logic [7:0] b);
    @(posedge clk);
    byte_vld <= 1'b1;
    is_data <= d;
    byte_in <= b;
    @(posedge clk);
    byte_vld <= 1'b0;
    byte_in <= ~b; // Stale value would hide a late sample
  endtask
  // One read request pulse
  task rd();
    @(posedge clk);
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
  endtask
endmodule // epu_host

// ==== testbench/epu_core_tb.sv ====
// Purpose: self-checking bench for the update option and frame memory block
// Assumes: host model drives all byte inputs
// Notes: memory survives reset, so reset is used to rewind the pointer
`timescale 1ns/1ps
module epu_core_tb;
  logic clk = 1'b0; // 200 MHz clock
  logic rst_b = 1'b0; // Reset, active low
  wire byte_vld, is_data, rd_req, rd_vld_r, disp_mode2, seq_busy; // Strobes and flags
  wire [7:0] byte_in, rd_data_r, upd_opt_r, rd_sel_r; // Bytes
  wire [2:0] stage; // Stage code
  wire [13:0] addr_ptr; // Pointer
  int errors = 0; // Mismatch count
  int tests_run = 0; // Comparison count
  logic [7:0] exp_q[$]; // Expected read answers
  logic [7:0] mem[8]; // Bytes written
  always #2.5 clk = ~clk;
  epu_host host_u (.clk, .byte_vld, .is_data, .byte_in, .rd_req);
  epu_core dut_u (.clk, .rst_b, .byte_vld, .is_data, .byte_in, .rd_req, .rd_data_r, .rd_vld_r,
    .upd_opt_r, .rd_sel_r, .stage, .disp_mode2, .seq_busy, .addr_ptr);
  // Single comparison point
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset for four cycles, then reset values
  task rst;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk(upd_opt_r, 8'hff);
    chk(rd_sel_r, 8'h00);
  endtask
  // Option write, extra data ignored, then stage walk sampled mid-stage
  task run_opt(input logic [7:0] o, input logic [17:0] sq);
    host_u.send(1'b0, 8'h22);
    host_u.send(1'b1, o);
    host_u.send(1'b1, ~o);
    #1 chk(upd_opt_r, o);
    host_u.send(1'b0, 8'h20);
    repeat (6) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      #1 chk(stage, sq[3*i+:3]);
      if (i == 0) chk(disp_mode2, o[3]);
      chk(seq_busy, sq[3*i+:3] != 3'h0);
      repeat (8) @(posedge clk);
    end
  endtask
  // Watcher: each answer against the oldest note; no note means a stray answer
  always @(posedge clk) begin
    if (rd_vld_r === 1'b1) begin
      if (exp_q.size() == 0) chk(rd_data_r, 16'h0100);
      else chk(rd_data_r, exp_q.pop_front());
    end
  end
  initial begin
    #50000;
    errors++;
    summarize();
  end
  initial begin
    void'($urandom(32'h6a76));
    rst();
    run_opt(8'hc7, 18'h78d1);
    run_opt(8'hcf, 18'h78d1);
    run_opt(8'hb1, 18'h0fa9);
    run_opt(8'hb9, 18'h0fa9);
    run_opt(8'h91, 18'h01f1);
    run_opt(8'h99, 18'h01f1);
    $display("update options done");
    rst();
    host_u.send(1'b0, 8'h24);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) host_u.send(1'b0, 8'h26);
      mem[i] = $urandom;
      host_u.send(1'b1, mem[i]);
    end
    #1 chk(addr_ptr, 14'h0008);
    rst();
    for (int p = 0; p < 2; p++) begin
      host_u.send(1'b0, 8'h41);
      host_u.send(1'b1, p[7:0]);
      host_u.rd(); // Ignored outside a read burst
      host_u.send(1'b0, 8'h27);
      exp_q.push_back(8'h00);
      host_u.rd();
      for (int i = 0; i < 4; i++) begin
        exp_q.push_back(mem[4*p+i]);
        host_u.rd();
      end
      repeat (4) @(posedge clk);
    end
    #1 chk(exp_q.size(), 16'h0000);
    chk(addr_ptr, 14'h0008);
    $display("frame memory done");
    summarize();
  end
endmodule // epu_core_tb
